//--- core/act_control.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module act_control
  import act_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conversion sequencing
  input wire logic sw_start,
  input wire logic external_trigger_select,
  input wire logic ext_trigger,
  input wire act_conv_t conv_in,
  output logic conversion_start_busy,
  output logic sample_enable,
  output logic conv_start,
  // Comparator results towards the PWM
  output logic compare_event,
  output logic fault_brake,
  output logic pwm_run_clear,
  // Digital input gating
  input wire logic [7:0] port0_pin_in,
  input wire logic pin26_in,
  input wire logic pin20_in,
  output logic [7:0] port0_din,
  output logic pin26_din,
  output logic pin20_din
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  act_ctl_t ctl_r;
  logic compare_output_r;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] threshold_r;
  logic [7:0] delay_low_r;
  logic [7:0] acq_extend_r;
  logic [7:0] port0_disc_r;
  act_state_t state_r;
  logic [DELAY_W-1:0] cnt_r;
  logic conv_start_r;
  logic compare_event_r;
  logic fault_brake_r;
  logic pwm_run_clear_r;

  logic [7:0] word_idx;
  logic addr_ok;
  logic wr_en;
  logic hit_known;
  logic [7:0] rd_byte;
  logic [DELAY_W-1:0] delay_count;
  logic [DELAY_W-1:0] acq_cycles;
  logic cmp_hit;
  logic cmp_update;
  logic ext_take;
  logic sw_take;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign word_idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == WORD_LSB) && (paddr[ADDR_W-1:10] == '0);
  assign wr_en = psel && penable && pwrite && hit_known && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_known;

  // Read mux; reserved bits and unused lanes read zero
  always_comb begin
    hit_known = addr_ok;
    rd_byte = RST_BYTE;
    unique case (word_idx)
      IDX_RESULT_LOW: rd_byte = {6'h00, result_r[LOW_W-1:0]};
      IDX_RESULT_HIGH: rd_byte = result_r[RESULT_W-1:LOW_W];
      IDX_THRESH_LOW: rd_byte = {6'h00, threshold_r[LOW_W-1:0]};
      IDX_THRESH_HIGH: rd_byte = threshold_r[RESULT_W-1:LOW_W];
      IDX_CMP_PIN_CTRL: begin
        rd_byte[CTL_BRAKE_EN] = ctl_r.compare_brake_enable;
        rd_byte[CTL_POLARITY] = ctl_r.compare_polarity;
        rd_byte[CTL_CMP_EN] = ctl_r.comparator_enable;
        rd_byte[CTL_CMP_OUT] = compare_output_r;
        rd_byte[CTL_PIN26_DIS] = ctl_r.pin26_input_disable;
        rd_byte[CTL_PIN20_DIS] = ctl_r.pin20_input_disable;
        rd_byte[CTL_DELAY_MSB] = ctl_r.trigger_delay_msb;
      end
      IDX_TRIG_DELAY_LOW: rd_byte = delay_low_r;
      IDX_ACQ_EXTEND: rd_byte = acq_extend_r;
      IDX_PORT0_DISC: rd_byte = port0_disc_r;
      default: hit_known = 1'b0;
    endcase
  end

  // Read data is registered so the bus sees a flop output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------
  // Control bits; the compare output bit ignores writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_r <= '0;
    end else if (wr_en && word_idx == IDX_CMP_PIN_CTRL) begin
      ctl_r.compare_brake_enable <= pwdata[CTL_BRAKE_EN];
      ctl_r.compare_polarity <= pwdata[CTL_POLARITY];
      ctl_r.comparator_enable <= pwdata[CTL_CMP_EN];
      ctl_r.pin26_input_disable <= pwdata[CTL_PIN26_DIS];
      ctl_r.pin20_input_disable <= pwdata[CTL_PIN20_DIS];
      ctl_r.trigger_delay_msb <= pwdata[CTL_DELAY_MSB];
    end
  end

  // Threshold halves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      threshold_r <= RST_RESULT;
    end else if (wr_en && word_idx == IDX_THRESH_LOW) begin
      threshold_r[LOW_W-1:0] <= pwdata[LOW_W-1:0];
    end else if (wr_en && word_idx == IDX_THRESH_HIGH) begin
      threshold_r[RESULT_W-1:LOW_W] <= pwdata[7:0];
    end
  end

  // Delay, acquisition and disconnect bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_low_r <= RST_BYTE;
      acq_extend_r <= RST_BYTE;
      port0_disc_r <= RST_BYTE;
    end else if (wr_en) begin
      if (word_idx == IDX_TRIG_DELAY_LOW) begin
        delay_low_r <= pwdata[7:0];
      end
      if (word_idx == IDX_ACQ_EXTEND) begin
        acq_extend_r <= pwdata[7:0];
      end
      if (word_idx == IDX_PORT0_DISC) begin
        port0_disc_r <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  assign delay_count = {ctl_r.trigger_delay_msb, delay_low_r};
  assign acq_cycles = ACQ_BASE_CYCLES + {1'b0, acq_extend_r};
  assign sw_take = sw_start && state_r == ACT_IDLE;
  // Busy blocks triggers until the converter reports done
  assign ext_take = ext_trigger && external_trigger_select && state_r == ACT_IDLE && !sw_start;
  assign conversion_start_busy = state_r != ACT_IDLE;
  assign sample_enable = state_r == ACT_ACQUIRE;

  // Sequencer: software start skips the delay stage entirely
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ACT_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      unique case (state_r)
        ACT_IDLE: begin
          if (sw_take) begin
            state_r <= ACT_ACQUIRE;
            cnt_r <= acq_cycles - CNT_ONE;
          end else if (ext_take && delay_count == CNT_ZERO) begin
            state_r <= ACT_ACQUIRE;
            cnt_r <= acq_cycles - CNT_ONE;
          end else if (ext_take) begin
            state_r <= ACT_DELAY;
            cnt_r <= delay_count - CNT_ONE;
          end
        end
        ACT_DELAY: begin
          if (cnt_r == CNT_ZERO) begin
            state_r <= ACT_ACQUIRE;
            cnt_r <= acq_cycles - CNT_ONE;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ACT_ACQUIRE: begin
          if (cnt_r == CNT_ZERO) begin
            state_r <= ACT_CONVERT;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ACT_CONVERT: begin
          if (conv_in.done) begin
            state_r <= ACT_IDLE;
          end
        end
      endcase
    end
  end

  // One-cycle start pulse to the converter as acquisition ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= state_r == ACT_ACQUIRE && cnt_r == CNT_ZERO;
    end
  end
  assign conv_start = conv_start_r;

  // ---------------------------------------------------------------
  // Result capture and comparator
  // ---------------------------------------------------------------
  // Compare against the fresh data, not the stored result
  assign cmp_hit = ctl_r.compare_polarity ? (conv_in.data < threshold_r)
                                          : (conv_in.data >= threshold_r);
  assign cmp_update = conv_in.done && state_r == ACT_CONVERT && ctl_r.comparator_enable;

  // Result is captured at every conversion end; the compare output only while the comparator is enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_r <= RST_RESULT;
      compare_output_r <= 1'b0;
    end else if (conv_in.done && state_r == ACT_CONVERT) begin
      result_r <= conv_in.data;
      if (ctl_r.comparator_enable) begin
        compare_output_r <= cmp_hit;
      end
    end
  end

  // Event and brake pulses follow a compare result of 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compare_event_r <= 1'b0;
      fault_brake_r <= 1'b0;
      pwm_run_clear_r <= 1'b0;
    end else begin
      compare_event_r <= cmp_update && cmp_hit;
      fault_brake_r <= cmp_update && cmp_hit && ctl_r.compare_brake_enable;
      pwm_run_clear_r <= cmp_update && cmp_hit && ctl_r.compare_brake_enable;
    end
  end
  assign compare_event = compare_event_r;
  assign fault_brake = fault_brake_r;
  assign pwm_run_clear = pwm_run_clear_r;

  // ---------------------------------------------------------------
  // Digital input gating
  // ---------------------------------------------------------------
  logic [9:0] pin_meta_r;
  logic [9:0] pin_sync_r;
  logic [9:0] pin_gate;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {pin26_in, pin20_in, port0_pin_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pin_gate = {ctl_r.pin26_input_disable, ctl_r.pin20_input_disable, port0_disc_r};

  // Disconnected pins read zero regardless of the pad level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port0_din <= RST_BYTE;
      pin26_din <= 1'b0;
      pin20_din <= 1'b0;
    end else begin
      port0_din <= pin_sync_r[7:0] & ~pin_gate[7:0];
      pin20_din <= pin_sync_r[8] & ~pin_gate[8];
      pin26_din <= pin_sync_r[9] & ~pin_gate[9];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [DELAY_W:0] stay_cnt_r;

  // Cycles spent in the current state, idle included
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stay_cnt_r <= '0;
    end else if (state_r != $past(state_r)) begin
      stay_cnt_r <= {{(DELAY_W){1'b0}}, 1'b1};
    end else begin
      stay_cnt_r <= stay_cnt_r + 1'b1;
    end
  end

  sequence s_done_cmp;
    conv_in.done && state_r == ACT_CONVERT && ctl_r.comparator_enable;
  endsequence

  sequence s_ext_idle;
    ext_trigger && external_trigger_select && state_r == ACT_IDLE && !sw_start;
  endsequence

  a_cmp_ge_pol: assert property (@(posedge clk) disable iff (sys_rst)
    s_done_cmp and !ctl_r.compare_polarity |=> compare_output_r == ($past(conv_in.data) >= $past(threshold_r)))
    else $error("compare output wrong for polarity 0");

  a_cmp_lt_pol: assert property (@(posedge clk) disable iff (sys_rst)
    s_done_cmp and ctl_r.compare_polarity |=> compare_output_r == ($past(conv_in.data) < $past(threshold_r)))
    else $error("compare output wrong for polarity 1");

  a_cmp_off_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !ctl_r.comparator_enable |=> $stable(compare_output_r) && !compare_event)
    else $error("disabled comparator changed output");

  a_brake_run_clear: assert property (@(posedge clk) disable iff (sys_rst)
    s_done_cmp and cmp_hit && ctl_r.compare_brake_enable |=> fault_brake && pwm_run_clear && compare_event)
    else $error("fault brake not asserted");

  a_result_same_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    conv_in.done && state_r == ACT_CONVERT |=> result_r == $past(conv_in.data) && state_r == ACT_IDLE)
    else $error("result not captured at conversion end");

  // Each pin is judged on its own bit, so a swapped gate is caught
  a_pin_disable_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (ctl_r.pin26_input_disable |=> !pin26_din) and (ctl_r.pin20_input_disable |=> !pin20_din))
    else $error("disabled pin read nonzero");

  a_port0_disc_zero: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> (port0_din & $past(port0_disc_r)) == 8'h00)
    else $error("disconnected port bit read nonzero");

  a_acq_length: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ACT_ACQUIRE ##1 state_r == ACT_CONVERT |-> stay_cnt_r == {1'b0, $past(acq_cycles)})
    else $error("acquisition length wrong");

  a_delay_length: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ACT_DELAY ##1 state_r == ACT_ACQUIRE |-> stay_cnt_r == {1'b0, $past(delay_count)})
    else $error("trigger delay length wrong");

  a_zero_delay: assert property (@(posedge clk) disable iff (sys_rst)
    s_ext_idle and delay_count == CNT_ZERO |=> state_r == ACT_ACQUIRE)
    else $error("zero delay did not start at once");

  a_sw_no_delay: assert property (@(posedge clk) disable iff (sys_rst)
    sw_start && state_r == ACT_IDLE |=> state_r == ACT_ACQUIRE)
    else $error("software start was delayed");

  a_busy_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ACT_CONVERT && !conv_in.done |=> state_r == ACT_CONVERT)
    else $error("busy sequencer left convert state");

endmodule

//--- core/act_pkg.sv
package act_pkg;

  // ---------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_RESULT_LOW = 8'hC2;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'hC3;
  localparam logic [7:0] IDX_THRESH_LOW = 8'hCE;
  localparam logic [7:0] IDX_THRESH_HIGH = 8'hCF;
  localparam logic [7:0] IDX_CMP_PIN_CTRL = 8'hE2;
  localparam logic [7:0] IDX_TRIG_DELAY_LOW = 8'hE3;
  localparam logic [7:0] IDX_ACQ_EXTEND = 8'hF2;
  localparam logic [7:0] IDX_PORT0_DISC = 8'hF6;
  localparam logic [1:0] WORD_LSB = 2'h0;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int RESULT_W = 10;
  localparam int DELAY_W = 9;
  localparam int LOW_W = 2;
  localparam int CTL_BRAKE_EN = 7;
  localparam int CTL_POLARITY = 6;
  localparam int CTL_CMP_EN = 5;
  localparam int CTL_CMP_OUT = 4;
  localparam int CTL_PIN26_DIS = 3;
  localparam int CTL_PIN20_DIS = 2;
  localparam int CTL_DELAY_MSB = 0;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [RESULT_W-1:0] RST_RESULT = 10'h000;
  localparam logic [DELAY_W-1:0] ACQ_BASE_CYCLES = 9'h006;
  localparam logic [DELAY_W-1:0] CNT_ONE = 9'h001;
  localparam logic [DELAY_W-1:0] CNT_ZERO = 9'h000;

  // Sequencer states, Gray coded along idle-delay-acquire-convert
  typedef enum logic [1:0] {
    ACT_IDLE = 2'h0,
    ACT_DELAY = 2'h1,
    ACT_ACQUIRE = 2'h3,
    ACT_CONVERT = 2'h2
  } act_state_t;

  // Writable fields of the compare and pin control register
  typedef struct packed {
    logic compare_brake_enable;
    logic compare_polarity;
    logic comparator_enable;
    logic pin26_input_disable;
    logic pin20_input_disable;
    logic trigger_delay_msb;
  } act_ctl_t;

  // Result delivered by the analog converter
  typedef struct packed {
    logic done;
    logic [RESULT_W-1:0] data;
  } act_conv_t;

endpackage

//--- verification/act_conv_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Converter model: done arrives lat+2 cycles after conv_start
// ---------------------------------------------
module act_conv_model
  import act_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_start,
  input wire logic [RESULT_W-1:0] data_val,
  input wire logic [7:0] lat,
  output act_conv_t conv_out
);
  logic [7:0] cnt_r;
  logic run_r;

  // Data toggles outside done, so a stale result is never mistaken for a fresh one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
      conv_out <= '0;
    end else begin
      conv_out.done <= 1'b0;
      conv_out.data <= ~conv_out.data;
      if (conv_start) begin
        run_r <= 1'b1;
        cnt_r <= lat;
      end else if (run_r) begin
        if (cnt_r == 8'h00) begin
          run_r <= 1'b0;
          conv_out.done <= 1'b1;
          conv_out.data <= data_val;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import act_pkg::*;
  localparam logic [7:0] MAP [8] = '{IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_THRESH_LOW, IDX_THRESH_HIGH,
    IDX_CMP_PIN_CTRL, IDX_TRIG_DELAY_LOW, IDX_ACQ_EXTEND, IDX_PORT0_DISC};
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, sw_start, ext_sel, ext_trigger;
  logic busy, sample_enable, conv_start, compare_event, fault_brake, pwm_run_clear;
  logic pin26_in, pin20_in, pin26_din, pin20_din, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] port0_pin_in, port0_din, rdat, lat;
  logic [RESULT_W-1:0] data_val;
  act_conv_t conv_in;
  int num_errors, compares, acq_n, dly_n, cs_n, ev_n, brk_n, clr_n, busy_n, post_n;

  act_control u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_start(sw_start), .external_trigger_select(ext_sel), .ext_trigger(ext_trigger), .conv_in(conv_in),
    .conversion_start_busy(busy), .sample_enable(sample_enable), .conv_start(conv_start),
    .compare_event(compare_event), .fault_brake(fault_brake), .pwm_run_clear(pwm_run_clear),
    .port0_pin_in(port0_pin_in), .pin26_in(pin26_in), .pin20_in(pin20_in), .port0_din(port0_din),
    .pin26_din(pin26_din), .pin20_din(pin20_din));

  act_conv_model u_model (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start), .data_val(data_val),
    .lat(lat), .conv_out(conv_in));

  // ---------------------------------------------
  // Reporting
  // ---------------------------------------------
  task results();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task fail(input string msg);
    num_errors++;
    $display("ERROR %0t %s", $time, msg);
  endtask

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask

  task chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail($sformatf("bit %b expected %b", got, exp));
  endtask

  task chk_count(input int got, input int exp);
    compares++;
    if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
  endtask

  // ---------------------------------------------
  // Bus and conversion drivers
  // ---------------------------------------------
  // Request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, WORD_LSB};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail("bus wait limit");
      results();
    end
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wrd(input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] exp);
    apb(1'b1, idx, wd);
    apb(1'b0, idx, 8'h00);
    chk_byte(rdat, exp);
  endtask

  // Starts one conversion and tallies what the ports show, cycle by cycle
  task conv(input logic ext, input logic [RESULT_W-1:0] data, input logic poke);
    int i;
    logic seen;
    {acq_n, dly_n, cs_n, ev_n, brk_n, clr_n, busy_n, post_n} = '0;
    seen = 1'b0;
    @(posedge clk);
    data_val <= data;
    if (ext) ext_trigger <= 1'b1;
    else sw_start <= 1'b1;
    @(posedge clk);
    ext_trigger <= 1'b0;
    sw_start <= 1'b0;
    for (i = 0; i < 2000; i++) begin
      @(negedge clk);
      if (busy === 1'b1 || sample_enable === 1'b1) seen = 1'b1;
      busy_n += int'(busy === 1'b1);
      if (sample_enable === 1'b1) acq_n++;
      else if (acq_n == 0) dly_n++;
      cs_n += int'(conv_start === 1'b1);
      ev_n += int'(compare_event === 1'b1);
      brk_n += int'(fault_brake === 1'b1);
      clr_n += int'(pwm_run_clear === 1'b1);
      if (seen && busy !== 1'b1) break;
      if (!seen && i > 300) break;
      if (poke && conv_start === 1'b1) begin
        @(posedge clk);
        ext_trigger <= 1'b1;
        @(posedge clk);
        ext_trigger <= 1'b0;
      end
    end
    if (i == 2000) begin
      fail("conversion wait limit");
      results();
    end
    repeat (3) begin
      @(negedge clk);
      ev_n += int'(compare_event === 1'b1);
      brk_n += int'(fault_brake === 1'b1);
      clr_n += int'(pwm_run_clear === 1'b1);
      post_n += int'(busy === 1'b1 || sample_enable === 1'b1);
    end
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task t_regs();
    foreach (MAP[k]) begin
      apb(1'b0, MAP[k], 8'h00);
      chk_byte(rdat, RST_BYTE);
    end
    apb(1'b0, 8'h10, 8'h00);
    chk_bit(rerr, 1'b1);
    chk_byte(rdat, 8'h00);
    wrd(IDX_THRESH_HIGH, 8'hA5, 8'hA5);
    wrd(IDX_THRESH_LOW, 8'h03, 8'h03);
    wrd(IDX_RESULT_HIGH, 8'hFF, 8'h00);
    wrd(IDX_CMP_PIN_CTRL, 8'hFF, 8'hED);
    wrd(IDX_TRIG_DELAY_LOW, 8'h5A, 8'h5A);
    wrd(IDX_ACQ_EXTEND, 8'h7F, 8'h7F);
    wrd(IDX_ACQ_EXTEND, 8'h00, 8'h00);
    wrd(IDX_CMP_PIN_CTRL, 8'h00, 8'h00);
  endtask

  task t_gate();
    @(posedge clk);
    port0_pin_in <= 8'hFF;
    pin26_in <= 1'b1;
    pin20_in <= 1'b1;
    apb(1'b1, IDX_PORT0_DISC, 8'hA5);
    apb(1'b1, IDX_CMP_PIN_CTRL, 8'h0C);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk_byte(port0_din, 8'h5A);
    chk_bit(pin26_din, 1'b0);
    chk_bit(pin20_din, 1'b0);
    apb(1'b1, IDX_PORT0_DISC, 8'h00);
    apb(1'b1, IDX_CMP_PIN_CTRL, 8'h04);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk_byte(port0_din, 8'hFF);
    chk_bit(pin26_din, 1'b1);
    chk_bit(pin20_din, 1'b0);
    apb(1'b1, IDX_CMP_PIN_CTRL, 8'h00);
  endtask

  // Prompt and slow converter, minimum and extended acquisition
  task t_acq();
    logic [RESULT_W-1:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 10'h148 : 10'h2B7;
      lat <= k ? 8'h14 : 8'h00;
      apb(1'b1, IDX_ACQ_EXTEND, 8'(k * 3));
      conv(1'b0, d, 1'b0);
      chk_count(acq_n, int'(ACQ_BASE_CYCLES) + k * 3);
      chk_count(dly_n, 0);
      chk_count(cs_n, 1);
      apb(1'b0, IDX_RESULT_HIGH, 8'h00);
      chk_byte(rdat, d[9:2]);
      apb(1'b0, IDX_RESULT_LOW, 8'h00);
      chk_byte(rdat, {6'h00, d[1:0]});
    end
    apb(1'b1, IDX_ACQ_EXTEND, 8'h00);
  endtask

  task automatic t_delay();
    logic [DELAY_W-1:0] dl [3] = '{9'h000, 9'h001, 9'h105};
    lat <= 8'h00;
    ext_sel <= 1'b1;
    foreach (dl[k]) begin
      apb(1'b1, IDX_TRIG_DELAY_LOW, dl[k][7:0]);
      apb(1'b1, IDX_CMP_PIN_CTRL, {7'h00, dl[k][8]});
      conv(1'b1, 10'h0AA, 1'b0);
      chk_count(dly_n, int'(dl[k]));
      chk_count(acq_n, 6);
    end
    conv(1'b0, 10'h0AA, 1'b0);
    chk_count(dly_n, 0);
    apb(1'b1, IDX_TRIG_DELAY_LOW, 8'h00);
    apb(1'b1, IDX_CMP_PIN_CTRL, 8'h00);
    lat <= 8'h14;
    conv(1'b1, 10'h0AA, 1'b1);
    chk_count(cs_n, 1);
    chk_count(post_n, 0);
    ext_sel <= 1'b0;
    conv(1'b1, 10'h0AA, 1'b0);
    chk_count(busy_n + acq_n, 0);
  endtask

  // Both polarities at the threshold boundary, then brake and comparator off
  task automatic t_cmp();
    logic [RESULT_W-1:0] dt [6] = '{10'h200, 10'h1FF, 10'h1FF, 10'h200, 10'h3FF, 10'h000};
    logic [7:0] ct [6] = '{8'hA0, 8'hA0, 8'hE0, 8'hE0, 8'h20, 8'h00};
    logic [5:0] hit = 6'b010101;
    logic [5:0] brk = 6'b000101;
    logic [5:0] out = 6'b110101;
    lat <= 8'h00;
    apb(1'b1, IDX_THRESH_HIGH, 8'h80);
    apb(1'b1, IDX_THRESH_LOW, 8'h00);
    foreach (dt[k]) begin
      apb(1'b1, IDX_CMP_PIN_CTRL, ct[k]);
      conv(1'b0, dt[k], 1'b0);
      chk_count(ev_n, int'(hit[k]));
      chk_count(brk_n, int'(brk[k]));
      chk_count(clr_n, int'(brk[k]));
      apb(1'b0, IDX_CMP_PIN_CTRL, 8'h00);
      chk_byte(rdat, ct[k] | {3'h0, out[k], 4'h0});
    end
  endtask

  // Clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {sys_rst, psel, penable, pwrite, sw_start, ext_sel, ext_trigger, pin26_in, pin20_in} = 9'h100;
    paddr = '0;
    pwdata = '0;
    port0_pin_in = 8'h00;
    lat = 8'h00;
    data_val = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_gate();
    t_acq();
    t_delay();
    t_cmp();
    results();
  end
endmodule
